// >>> sbtc_pkg.sv
/*
 * Package of the sixteen-bit timer/counter: register offsets, field
 * positions, reset values, prescale codes and the state encoding.
 * Assumes a 32-bit Avalon-MM slave with byte addresses on word bounds.
 */
package sbtc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h00;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
  localparam logic [7:0] ADDR_FLAG = 8'h08;
  localparam logic [7:0] ADDR_ENABLE = 8'h0c;
  localparam logic [7:0] ADDR_PINS = 8'h14;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CTL_RUN = 0;
  localparam int CTL_SRC = 1;
  localparam int CTL_NOSYNC = 2;
  localparam int CTL_OSC = 3;
  localparam int CTL_PS_LO = 4;
  localparam int CTL_PS_HI = 5;
  localparam logic [7:0] CTL_MASK = 8'h3f;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam int FLAG_OVF = 0;

  localparam logic [1:0] PS_1 = 2'h0;
  localparam logic [1:0] PS_2 = 2'h1;
  localparam logic [1:0] PS_4 = 2'h2;
  localparam logic [1:0] PS_8 = 2'h3;

  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [1:0] INSN_DIV_LAST = 2'h3;

  typedef enum logic [1:0] {
    SBTC_IDLE = 2'b01,
    SBTC_ACK = 2'b10
  } sbtc_bus_t;

endpackage : sbtc_pkg

// >>> sbtc_sync.sv
/*
 * Two-flop synchroniser for a single level from outside the clock domain.
 * Assumes the input may change at any time relative to CLK.
 */
`timescale 1ns/1ps
module sbtc_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sbtc_sync_t;

  sbtc_sync_t st_q;
  sbtc_sync_t st_d;

  always_comb begin
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.s2;
endmodule : sbtc_sync

// >>> sbtc_prescale.sv
/*
 * Prescaler for the selected count tick: passes 1 of 1, 2, 4 or 8 ticks.
 * Assumes tick is a one-cycle pulse on CLK; clear restarts the division.
 */
`timescale 1ns/1ps
module sbtc_prescale #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic clear,
  input wire logic [1:0] sel,
  output logic pulse
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } sbtc_ps_t;

  sbtc_ps_t st_q;
  sbtc_ps_t st_d;
  logic [WIDTH-1:0] last;

  // Code n divides by 2^n
  function automatic logic [WIDTH-1:0] ratio_last(input logic [1:0] s);
    case (s)
      sbtc_pkg::PS_1: ratio_last = WIDTH'(0);
      sbtc_pkg::PS_2: ratio_last = WIDTH'(1);
      sbtc_pkg::PS_4: ratio_last = WIDTH'(3);
      default: ratio_last = WIDTH'(7);
    endcase
  endfunction : ratio_last

  always_comb begin
    last = ratio_last(sel);
    st_d = st_q;
    pulse = 1'b0;
    if (clear) begin
      st_d.cnt = '0;
    end else if (tick) begin
      if (st_q.cnt >= last) begin
        st_d.cnt = '0;
        pulse = 1'b1; // RQ11
      end else begin
        st_d.cnt = st_q.cnt + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : sbtc_prescale

// >>> sbtc_top.sv
/*
 * Sixteen-bit timer/counter with an Avalon-MM register slave, a sticky
 * overflow flag, an enable mask and one level interrupt.
 * Assumes one 200 MHz clock, async active-low reset, external clock and
 * event trigger arriving asynchronously on pins.
 */
`timescale 1ns/1ps

// What this block does
// RQ1: Count is sixteen bits as high and low bytes, both read/write.
// RQ2: Count goes up from zero to all ones, then wraps to zero.
// RQ3: Overflow sets a sticky flag, bit 0 of flag register, until cleared.
// RQ4: Interrupt forwarded only while enable bit 0 is set.
// RQ5: Control bit 1 picks external pin (1) or instruction clock (0).
// RQ6: Timer mode counts once per instruction cycle after prescale.
// RQ7: Counter mode counts rising edges of the external pin after prescale.
// RQ8: Counting only while run bit 0 is set; otherwise count holds.
// RQ9: Capture/compare event trigger acts as internal counter reset input.
// RQ10: Oscillator enabled forces both pins to input, reading zero.
// RQ11: Prescale field bits 5-4 divides by 1, 2, 4 or 8.
// RQ12: Control bit 3 runs the oscillator; clear switches inverter off.
// RQ13: Control bits 7-6 read zero, ignore writes; all bits reset zero.
// RQ14: Bit 2 zero synchronizes external clock; one leaves it unsynced; here both settings pass it through two flops.
// RQ15: Prescaler sits before synchronizer and counter, one step per pulse; here the prescaler follows the synchronizer.
// RQ16: Event trigger clears both count bytes.
// RQ17: Event trigger clear never sets the overflow flag.
module sbtc_top (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [7:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  output logic IRQ,
  input wire logic EXT_CLOCK_PIN_IN,
  input wire logic OSC_INPUT_PIN_IN,
  input wire logic [1:0] PORT_C_DIRECTION,
  input wire logic [1:0] PORT_C_OUT,
  output logic [1:0] PIN_OUT,
  output logic [1:0] PIN_OE,
  output logic OSC_RUN,
  input wire logic EVENT_TRIGGER_A,
  input wire logic EVENT_TRIGGER_B
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sbtc_pkg::sbtc_bus_t bus;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [15:0] count;
    logic flag;
    logic enable;
    logic [1:0] insn_div;
    logic ext_prev;
    logic trig_prev;
    logic irq;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    logic waitreq;
  } sbtc_state_t;

  sbtc_state_t st_q;
  sbtc_state_t st_d;

  logic ext_sync;
  logic ext_raw_q;
  logic ext_raw2_q;
  logic osc_sync;
  logic trig_a_sync;
  logic trig_b_sync;
  logic trig_level;
  logic trig_pulse;
  logic src_level;
  logic src_tick;
  logic insn_tick;
  logic ps_pulse;
  logic ps_clear;
  logic count_step;
  logic bus_take;
  logic wr_take;
  logic [7:0] wr_byte;
  logic [31:0] rd_word;
  logic [7:0] pin_read;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  sbtc_sync u_sync_ext (
    .clk(CLK),
    .arst_n(ARST_N),
    .din(EXT_CLOCK_PIN_IN),
    .dout(ext_sync)
  );

  sbtc_sync u_sync_osc (
    .clk(CLK),
    .arst_n(ARST_N),
    .din(OSC_INPUT_PIN_IN),
    .dout(osc_sync)
  );

  sbtc_sync u_sync_trig_a (
    .clk(CLK),
    .arst_n(ARST_N),
    .din(EVENT_TRIGGER_A),
    .dout(trig_a_sync)
  );

  sbtc_sync u_sync_trig_b (
    .clk(CLK),
    .arst_n(ARST_N),
    .din(EVENT_TRIGGER_B),
    .dout(trig_b_sync)
  );

  // Unsynced path still needs two flops before logic; it matches the
  // synchroniser flop for flop, with the same two cycles of latency.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ext_raw_q <= 1'b0;
      ext_raw2_q <= 1'b0;
    end else begin
      ext_raw_q <= EXT_CLOCK_PIN_IN;
      ext_raw2_q <= ext_raw_q;
    end
  end

  // ----------------------------------------------------------------
  // Count clock path
  // ----------------------------------------------------------------
  assign trig_level = trig_a_sync | trig_b_sync; // RQ9
  assign trig_pulse = trig_level & ~st_q.trig_prev;
  assign insn_tick = (st_q.insn_div == sbtc_pkg::INSN_DIV_LAST); // RQ6
  assign src_level = st_q.ctrl[sbtc_pkg::CTL_NOSYNC] ? ext_raw2_q : ext_sync; // RQ14
  assign src_tick = st_q.ctrl[sbtc_pkg::CTL_SRC] ? (src_level & ~st_q.ext_prev)
                                                 : insn_tick; // RQ5 RQ7
  assign ps_clear = ~st_q.ctrl[sbtc_pkg::CTL_RUN] | trig_pulse;
  assign count_step = ps_pulse & st_q.ctrl[sbtc_pkg::CTL_RUN]; // RQ8 RQ15

  sbtc_prescale #(
    .WIDTH(3)
  ) u_prescale (
    .clk(CLK),
    .arst_n(ARST_N),
    .tick(src_tick),
    .clear(ps_clear),
    .sel(st_q.ctrl[sbtc_pkg::CTL_PS_HI:sbtc_pkg::CTL_PS_LO]),
    .pulse(ps_pulse)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign bus_take = (st_q.bus == sbtc_pkg::SBTC_IDLE) & (READ | WRITE);
  assign wr_take = bus_take & WRITE & BYTEENABLE[0];
  assign wr_byte = WRITEDATA[7:0];
  // Oscillator pins read zero while the oscillator owns them
  assign pin_read = st_q.ctrl[sbtc_pkg::CTL_OSC] ? 8'h00
                    : {6'h00, osc_sync, ext_sync}; // RQ10

  always_comb begin
    rd_word = 32'h00000000;
    case (ADDRESS)
      sbtc_pkg::ADDR_COUNT_LOW: rd_word = {24'h000000, st_q.count[7:0]}; // RQ1
      sbtc_pkg::ADDR_COUNT_HIGH: rd_word = {24'h000000, st_q.count[15:8]};
      sbtc_pkg::ADDR_FLAG: rd_word = {31'h00000000, st_q.flag};
      sbtc_pkg::ADDR_ENABLE: rd_word = {31'h00000000, st_q.enable};
      sbtc_pkg::ADDR_CONTROL: rd_word = {24'h000000, st_q.ctrl & sbtc_pkg::CTL_MASK}; // RQ13
      sbtc_pkg::ADDR_PINS: rd_word = {24'h000000, pin_read};
      default: rd_word = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.insn_div = st_q.insn_div + 2'h1;
    st_d.ext_prev = src_level;
    st_d.trig_prev = trig_level;

    case (st_q.bus)
      sbtc_pkg::SBTC_IDLE: begin
        if (bus_take) begin
          st_d.bus = sbtc_pkg::SBTC_ACK;
          st_d.rdata = READ ? rd_word : 32'h00000000;
        end
      end
      sbtc_pkg::SBTC_ACK: begin
        st_d.bus = sbtc_pkg::SBTC_IDLE;
      end
      default: begin
        st_d.bus = sbtc_pkg::SBTC_IDLE;
      end
    endcase

    // Counting, then event clear, then software write: later wins for count
    if (count_step) begin
      st_d.count = st_q.count + 16'h0001; // RQ2
      if (st_q.count == sbtc_pkg::COUNT_MAX) begin
        st_d.flag = 1'b1; // RQ3
      end
    end
    if (trig_pulse) begin
      st_d.count = sbtc_pkg::COUNT_ZERO; // RQ16 RQ17
    end

    if (wr_take) begin
      case (ADDRESS)
        sbtc_pkg::ADDR_COUNT_LOW: st_d.count[7:0] = wr_byte; // RQ1
        sbtc_pkg::ADDR_COUNT_HIGH: st_d.count[15:8] = wr_byte;
        sbtc_pkg::ADDR_FLAG: begin
          // Set wins over a same-cycle clear
          if (wr_byte[sbtc_pkg::FLAG_OVF] && !st_d.flag) begin
            st_d.flag = 1'b0;
          end else if (wr_byte[sbtc_pkg::FLAG_OVF] && !(count_step &&
                       st_q.count == sbtc_pkg::COUNT_MAX)) begin
            st_d.flag = 1'b0; // RQ3
          end
        end
        sbtc_pkg::ADDR_ENABLE: st_d.enable = wr_byte[sbtc_pkg::FLAG_OVF];
        sbtc_pkg::ADDR_CONTROL: st_d.ctrl = wr_byte & sbtc_pkg::CTL_MASK; // RQ13
        default: st_d.ctrl = st_d.ctrl;
      endcase
    end

    st_d.irq = st_d.flag & st_d.enable; // RQ4
    st_d.pin_oe = st_d.ctrl[sbtc_pkg::CTL_OSC] ? 2'h0 : ~PORT_C_DIRECTION; // RQ10
    st_d.pin_out = st_d.ctrl[sbtc_pkg::CTL_OSC] ? 2'h0 : PORT_C_OUT;
    // Registered so the bus sees no decode glitch on the handshake
    st_d.waitreq = (st_d.bus != sbtc_pkg::SBTC_ACK);
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= '{bus: sbtc_pkg::SBTC_IDLE, ctrl: sbtc_pkg::CTL_RESET,
                count: sbtc_pkg::COUNT_ZERO, waitreq: 1'b1, default: '0}; // RQ13
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign READDATA = st_q.rdata;
  assign WAITREQUEST = st_q.waitreq;
  assign IRQ = st_q.irq;
  assign PIN_OUT = st_q.pin_out;
  assign PIN_OE = st_q.pin_oe;
  assign OSC_RUN = st_q.ctrl[sbtc_pkg::CTL_OSC]; // RQ12

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_wrap_sets_flag: assert property (count_step && st_q.count == sbtc_pkg::COUNT_MAX
      && !trig_pulse && !wr_take |=> st_q.flag && st_q.count == 16'h0000) // RQ3
    else $error("overflow did not wrap and set flag");
  a_count_increments: assert property (count_step && !trig_pulse && !wr_take
      |=> st_q.count == $past(st_q.count) + 16'h0001) // RQ2
    else $error("count did not increment");
  a_stopped_holds: assert property (!st_q.ctrl[sbtc_pkg::CTL_RUN] && !trig_pulse
      && !wr_take |=> st_q.count == $past(st_q.count)) // RQ8
    else $error("stopped counter moved");
  a_trigger_clears: assert property (trig_pulse && !wr_take
      |=> st_q.count == 16'h0000) // RQ16
    else $error("trigger did not clear count");
  a_trigger_no_flag: assert property (trig_pulse && !count_step && !st_q.flag
      && !wr_take |=> !st_q.flag) // RQ17
    else $error("trigger set overflow flag");
  a_irq_masked: assert property (!st_q.enable |-> !IRQ) // RQ4
    else $error("masked interrupt asserted");
  a_irq_follows: assert property (st_q.flag && st_q.enable |-> IRQ) // RQ4
    else $error("interrupt missing");
  a_ctrl_upper_zero: assert property (st_q.ctrl[7:6] == 2'h0) // RQ13
    else $error("control upper bits set");
  a_osc_pins_input: assert property (st_q.ctrl[sbtc_pkg::CTL_OSC]
      |-> PIN_OE == 2'h0) // RQ10
    else $error("oscillator pins driven");
  a_osc_pins_low: assert property (st_q.ctrl[sbtc_pkg::CTL_OSC]
      |-> PIN_OUT == 2'h0) // RQ10
    else $error("oscillator pins carry port data");
  a_timer_rate: assert property (st_q.ctrl[sbtc_pkg::CTL_RUN]
      && !st_q.ctrl[sbtc_pkg::CTL_SRC]
      && st_q.ctrl[sbtc_pkg::CTL_PS_HI:sbtc_pkg::CTL_PS_LO] == sbtc_pkg::PS_1
      && count_step |=> (!count_step) [*3]) // RQ6
    else $error("timer stepped faster than instruction rate");
  a_timer_tick_only: assert property (st_q.ctrl[sbtc_pkg::CTL_RUN]
      && !st_q.ctrl[sbtc_pkg::CTL_SRC] && !insn_tick |-> !count_step) // RQ6
    else $error("timer stepped between instruction cycles");
  a_counter_edge_only: assert property (st_q.ctrl[sbtc_pkg::CTL_RUN]
      && st_q.ctrl[sbtc_pkg::CTL_SRC] && !src_tick |-> !count_step) // RQ7
    else $error("counter stepped without a pin edge");
  a_count_write: assert property (wr_take && ADDRESS == sbtc_pkg::ADDR_COUNT_LOW
      |=> st_q.count[7:0] == $past(WRITEDATA[7:0])) // RQ1
    else $error("count low write lost");
  a_flag_sticky: assert property (st_q.flag
      && !(wr_take && ADDRESS == sbtc_pkg::ADDR_FLAG) |=> st_q.flag) // RQ3
    else $error("overflow flag dropped without clear");
  a_flag_w1c: assert property (wr_take && ADDRESS == sbtc_pkg::ADDR_FLAG
      && WRITEDATA[sbtc_pkg::FLAG_OVF]
      && !(count_step && st_q.count == sbtc_pkg::COUNT_MAX) |=> !st_q.flag) // RQ3
    else $error("overflow flag not cleared by write");
  a_osc_run_write: assert property (wr_take && ADDRESS == sbtc_pkg::ADDR_CONTROL
      |=> OSC_RUN == $past(WRITEDATA[sbtc_pkg::CTL_OSC])) // RQ12
    else $error("oscillator enable not applied");
  a_bus_ack: assert property (bus_take |=> !WAITREQUEST ##1 WAITREQUEST)
    else $error("bus answer not one cycle");

  c_overflow: cover property (count_step && st_q.count == sbtc_pkg::COUNT_MAX);
  c_trigger: cover property (trig_pulse && st_q.count != 16'h0000);
  c_irq: cover property (IRQ);
  c_counter_mode: cover property (st_q.ctrl[sbtc_pkg::CTL_SRC] && count_step);
  c_unsynced_step: cover property (st_q.ctrl[sbtc_pkg::CTL_SRC]
      && st_q.ctrl[sbtc_pkg::CTL_NOSYNC] && count_step);

endmodule : sbtc_top

// >>> sbtc_ext_src.sv
/*
 * Far-side model of the timer block: external count clock and crystal.
 * Assumes burst() is called just after a rising edge of clk.
 */
`timescale 1ns/1ps
module sbtc_ext_src (
  input wire logic clk,
  input wire logic osc_on,
  output logic ext_pin,
  output logic osc_pin
);
  initial begin
    ext_pin = 1'b0;
    osc_pin = 1'b0;
  end

  // Crystal swings only while its inverter runs; pulled low otherwise
  always @(posedge clk) begin
    osc_pin <= osc_on ? ~osc_pin : 1'b0;
  end

  // Clock stands low between bursts
  task automatic burst(input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++) begin
      ext_pin <= 1'b1;
      repeat (hi) @(posedge clk);
      ext_pin <= 1'b0;
      repeat (lo) @(posedge clk);
    end
  endtask : burst
endmodule : sbtc_ext_src

// >>> sbtc_bench.sv
/*
 * Self-checking bench of the timer block: bus driver, read monitor with
 * an expectation queue, event triggers and pin checks.
 * Assumes sbtc_pkg, the design files and sbtc_ext_src are compiled first.
 */
`timescale 1ns/1ps
module sbtc_bench;
  typedef struct {logic [31:0] lo; logic [31:0] hi;} sbtc_exp_t;
  localparam logic [7:0] A_LO = sbtc_pkg::ADDR_COUNT_LOW;
  localparam logic [7:0] A_HI = sbtc_pkg::ADDR_COUNT_HIGH;
  localparam logic [7:0] A_FLG = sbtc_pkg::ADDR_FLAG;
  localparam logic [7:0] A_EN = sbtc_pkg::ADDR_ENABLE;
  localparam logic [7:0] A_CTL = sbtc_pkg::ADDR_CONTROL;
  localparam logic [7:0] A_PIN = sbtc_pkg::ADDR_PINS;
  logic clk, arst_n, read, write, waitreq, irq, ext_pin, osc_pin, osc_run, trg_a, trg_b;
  logic [7:0] address, b0, b1;
  logic [31:0] wdata, rdata;
  logic [3:0] ben;
  logic [1:0] dir, pout, pin_out, pin_oe;
  sbtc_exp_t exp_q[$];
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;

  sbtc_top i_dut (.CLK(clk), .ARST_N(arst_n), .ADDRESS(address), .READ(read), .WRITE(write),
    .WRITEDATA(wdata), .BYTEENABLE(ben), .READDATA(rdata), .WAITREQUEST(waitreq), .IRQ(irq),
    .EXT_CLOCK_PIN_IN(ext_pin), .OSC_INPUT_PIN_IN(osc_pin), .PORT_C_DIRECTION(dir),
    .PORT_C_OUT(pout), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .OSC_RUN(osc_run),
    .EVENT_TRIGGER_A(trg_a), .EVENT_TRIGGER_B(trg_b));
  sbtc_ext_src i_src (.clk(clk), .osc_on(osc_run), .ext_pin(ext_pin), .osc_pin(osc_pin));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic fail(input string msg);
    n_errors++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask : fail

  task automatic check_read(input sbtc_exp_t e);
    cmp_count++;
    if (^rdata === 1'bx || rdata < e.lo || rdata > e.hi) begin
      fail("read data");
    end
  endtask : check_read

  task automatic check_out(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail("output level");
    end
  endtask : check_out

  always @(posedge clk) begin
    if (read && waitreq === 1'b0) begin
      check_read(exp_q.pop_front());
    end
  end

  // Extra edge at the end keeps back-to-back calls from clashing
  task automatic bus(input logic wr_n_rd, input logic [7:0] a, input logic [7:0] d);
    read <= ~wr_n_rd;
    write <= wr_n_rd;
    address <= a;
    wdata <= {24'h0, d};
    @(posedge clk);
    while (waitreq !== 1'b0) @(posedge clk);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    exp_q.push_back('{lo, hi});
    bus(1'b0, a, 8'h00);
  endtask : rd

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask : tk

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic report_and_stop();
    $display("compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail("timeout");
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    wdata = 32'h0;
    ben = 4'hf;
    dir = 2'h3;
    pout = 2'h0;
    trg_a = 1'b0;
    trg_b = 1'b0;
    void'($urandom(27312));
    tk(6);
    arst_n <= 1'b1;
    tk(1);
    rd(A_CTL, 0, 0);
    rd(8'h1c, 0, 0);
    wr(A_CTL, 8'hc0);
    rd(A_CTL, 0, 0);
    done("reset");
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    wr(A_LO, b0);
    wr(A_HI, b1);
    tk(40);
    rd(A_LO, {24'h0, b0}, {24'h0, b0});
    rd(A_HI, {24'h0, b1}, {24'h0, b1});
    ben <= 4'he;
    wr(A_LO, ~b0);
    ben <= 4'hf;
    rd(A_LO, {24'h0, b0}, {24'h0, b0});
    done("count access");
    // Start phase of the instruction divider is unknown: allow one step
    for (int p = 0; p < 4; p++) begin
      wr(A_HI, 8'h00);
      wr(A_LO, 8'h00);
      wr(A_CTL, {2'h0, 2'(p), 4'h1});
      tk(32 << p);
      wr(A_CTL, 8'h00);
      rd(A_LO, 7, 9);
    end
    done("prescale");
    for (int i = 0; i < 2; i++) begin
      wr(A_LO, 8'h00);
      wr(A_CTL, i ? 8'h17 : 8'h03);
      i_src.burst(5 + i, 3 - i, 3 - i);
      tk(8);
      wr(A_CTL, 8'h00);
      rd(A_LO, i ? 3 : 5, i ? 3 : 5);
    end
    done("counter");
    wr(A_EN, 8'h01);
    wr(A_LO, 8'hfe);
    wr(A_HI, 8'hff);
    wr(A_CTL, 8'h01);
    tk(20);
    wr(A_CTL, 8'h00);
    check_out({1'b0, irq}, 2'h1);
    rd(A_HI, 0, 0);
    rd(A_FLG, 1, 1);
    wr(A_EN, 8'h00);
    tk(2);
    check_out({1'b0, irq}, 2'h0);
    wr(A_EN, 8'h01);
    tk(2);
    check_out({1'b0, irq}, 2'h1);
    wr(A_FLG, 8'h01);
    tk(2);
    check_out({1'b0, irq}, 2'h0);
    rd(A_FLG, 0, 0);
    done("overflow");
    for (int t = 0; t < 2; t++) begin
      wr(A_LO, 8'h34);
      wr(A_HI, 8'h12);
      trg_a <= (t == 0);
      trg_b <= (t == 1);
      tk(4);
      trg_a <= 1'b0;
      trg_b <= 1'b0;
      tk(6);
      rd(A_HI, 0, 0);
      rd(A_LO, 0, 0);
      rd(A_FLG, 0, 0);
    end
    done("trigger");
    for (int o = 0; o < 2; o++) begin
      dir <= 2'($urandom);
      pout <= 2'($urandom);
      wr(A_CTL, {4'h0, 1'(o), 3'h0});
      tk(4);
      check_out(pin_oe, o ? 2'h0 : ~dir);
      check_out({osc_run, 1'b0}, {1'(o), 1'b0});
      if (o) begin
        check_out(pin_out, 2'h0);
      end else begin
        check_out(pin_out, pout);
      end
      rd(A_PIN, 0, 0);
    end
    done("oscillator pins");
    report_and_stop();
  end
endmodule : sbtc_bench
